// [sap_audio_source.sv]
`timescale 1ns/1ps
module sap_audio_source #(
  parameter sap_pkg::sap_word_type LEFT_WORD  = 24'h000001,
  parameter sap_pkg::sap_word_type RIGHT_WORD = 24'h000002
) (
  input  wire logic clk_in,
  output logic      bit_clock_out,
  output logic      word_clock_out,
  output logic      data_out
);
  import sap_pkg::*;
  // ==========================================================
  // slave-side source: 8 clk bit period, 32 bits a phase, left-justified
  logic [8:0]   cnt_r = 9'h000;
  sap_word_type word;
  always_ff @(posedge clk_in) cnt_r <= cnt_r + 9'h001;
  assign word           = cnt_r[8] ? RIGHT_WORD : LEFT_WORD;
  assign bit_clock_out  = cnt_r[2];
  assign word_clock_out = ~cnt_r[8];
  // past the word the line toggles, so stale data never looks valid
  assign data_out = (cnt_r[7:3] < 5'h18) ? word[5'h17 - cnt_r[7:3]] : cnt_r[3];
endmodule

// [sap_clkgen.sv]
`timescale 1ns/1ps
`include "sap_regs.svh"

module sap_clkgen #(
  parameter int HALF_DIV = `SAP_HALF_DIV
) (
  input  wire logic                      clk_in,
  input  wire logic                      resetn_in,
  input  wire sap_pkg::sap_port_cfg_type cfg_in,
  input  wire logic                      bit_clock_in,
  input  wire logic                      word_clock_in,
  output logic                           bit_clock_out,
  output logic                           bit_clock_oe_out,
  output logic                           word_clock_out,
  output logic                           word_clock_oe_out,
  output sap_pkg::sap_port_ev_type       ev_out
);
  import sap_pkg::*;

  logic       bs1_r, bs2_r, bs3_r, ws1_r, ws2_r;
  logic [7:0] div_r, div_nxt;
  logic [5:0] bit_r, bit_nxt, phase_bits;
  logic       mb_r, mb_nxt, mw_r, mw_nxt, rise_r, rise_nxt, fall_r, fall_nxt;
  logic       pb_r, pb_nxt, pw_r, pw_nxt, oe_r;
  logic       last_s_r, last_s_nxt, last_l_r, last_l_nxt;
  logic       sb_now, sb_old;

  // ==========================================================
  // master divider and event decode
  always_comb begin
    div_nxt    = div_r + 8'h01;
    bit_nxt    = bit_r;
    mb_nxt     = mb_r;
    mw_nxt     = mw_r;
    rise_nxt   = 1'b0;
    fall_nxt   = 1'b0;
    phase_bits = cfg_in.bitclk_rate ? `SAP_PHASE_BITS_R1 : `SAP_PHASE_BITS_R0;
    if (div_r == 8'(HALF_DIV - 1)) begin
      div_nxt  = 8'h00;
      mb_nxt   = ~mb_r;
      rise_nxt = ~mb_r;
      fall_nxt = mb_r;
      if (mb_r) begin
        if (bit_r == phase_bits - 6'h01) begin
          bit_nxt = 6'h00;
          mw_nxt  = ~mw_r;
        end else begin
          bit_nxt = bit_r + 6'h01;
        end
      end
    end
    pb_nxt = mb_nxt ^ cfg_in.bitclk_polarity;
    pw_nxt = mw_nxt ^ cfg_in.wordclk_polarity;
    sb_now = bs2_r ^ cfg_in.bitclk_polarity;
    sb_old = bs3_r ^ cfg_in.bitclk_polarity;
    // slave clocks come through the same two stages as the data pin
    if (cfg_in.master_select) begin
      ev_out.sample = rise_r;
      ev_out.launch = fall_r;
      ev_out.left   = mw_r;
    end else begin
      ev_out.sample = sb_now & ~sb_old;
      ev_out.launch = ~sb_now & sb_old;
      ev_out.left   = ws2_r ^ cfg_in.wordclk_polarity;
    end
    ev_out.sample_phase = ev_out.sample & (ev_out.left != last_s_r);
    ev_out.launch_phase = ev_out.launch & (ev_out.left != last_l_r);
    last_s_nxt = ev_out.sample ? ev_out.left : last_s_r;
    last_l_nxt = ev_out.launch ? ev_out.left : last_l_r;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {bs1_r, bs2_r, bs3_r, ws1_r, ws2_r} <= 5'h00;
      div_r    <= 8'h00;
      bit_r    <= 6'h00;
      {mb_r, mw_r, rise_r, fall_r} <= 4'h0;
      {pb_r, pw_r, oe_r} <= 3'h0;
      last_s_r <= 1'b0;
      last_l_r <= 1'b0;
    end else begin
      bs1_r    <= bit_clock_in;
      bs2_r    <= bs1_r;
      bs3_r    <= bs2_r;
      ws1_r    <= word_clock_in;
      ws2_r    <= ws1_r;
      div_r    <= div_nxt;
      bit_r    <= bit_nxt;
      mb_r     <= mb_nxt;
      mw_r     <= mw_nxt;
      rise_r   <= rise_nxt;
      fall_r   <= fall_nxt;
      pb_r     <= pb_nxt;
      pw_r     <= pw_nxt;
      oe_r     <= cfg_in.master_select;
      last_s_r <= last_s_nxt;
      last_l_r <= last_l_nxt;
    end
  end

  assign bit_clock_out     = pb_r;
  assign word_clock_out    = pw_r;
  assign bit_clock_oe_out  = oe_r;
  assign word_clock_oe_out = oe_r;

endmodule

// [sap_pkg.sv]
`include "sap_regs.svh"

package sap_pkg;

  typedef struct packed {
    logic       master_select;
    logic       bitclk_rate;
    logic [1:0] word_resolution;
    logic       justify_sel;
    logic       first_bit_delay;
    logic       bitclk_polarity;
    logic       wordclk_polarity;
  } sap_port_cfg_type;

  typedef logic [`SAP_WORD_W-1:0] sap_word_type;

  typedef struct packed {
    sap_word_type left;
    sap_word_type right;
  } sap_stereo_type;

  typedef struct packed {
    logic validity;
    logic user;
    logic status;
  } sap_line_bits_type;

  // sample: active bit clock edge, launch: the opposite edge
  typedef struct packed {
    logic sample;
    logic launch;
    logic sample_phase;
    logic launch_phase;
    logic left;
  } sap_port_ev_type;

  typedef enum logic [2:0] {
    SAP_ST_POWERUP = 3'b001,
    SAP_ST_TRACK   = 3'b010,
    SAP_ST_LOCKED  = 3'b100
  } sap_lock_state_type;

endpackage

// [sap_regs.svh]
`ifndef SAP_REGS_SVH
`define SAP_REGS_SVH

// ==========================================================
// word resolution codes
`define SAP_RES_24        2'h0
`define SAP_RES_20        2'h1
`define SAP_RES_16        2'h2
`define SAP_RES_LINE      2'h3

// ==========================================================
// word widths
`define SAP_WORD_W        24
`define SAP_RES_BITS_24   6'h18
`define SAP_RES_BITS_20   6'h14
`define SAP_RES_BITS_16   6'h10
`define SAP_FRAME_BITS    6'h20

// ==========================================================
// bit clocks per word clock phase, by bit clock rate
`define SAP_PHASE_BITS_R0 6'h20
`define SAP_PHASE_BITS_R1 6'h10
`define SAP_HALF_DIV      4

// ==========================================================
// converter buffer, ratio and settling
`define SAP_BUF_DEPTH     4
`define SAP_RATIO_FRAC    6
`define SAP_RATIO_RESET   8'h40
`define SAP_RATIO_TOL     9'h001
`define SAP_SETTLE_CHANGE_FRAMES  9400
`define SAP_SETTLE_POWERUP_FRAMES 8300

// ==========================================================
// dither generators
`define SAP_LFSR_L_SEED   17'h1ACE1
`define SAP_LFSR_L_TAPS   17'h12000
`define SAP_LFSR_R_SEED   23'h35A5A5
`define SAP_LFSR_R_TAPS   23'h420000

`endif

// [sap_serial_src.sv]
`timescale 1ns/1ps
`include "sap_regs.svh"

// ==========================================================

module sap_serial_src #(
  parameter int HALF_DIV              = `SAP_HALF_DIV,
  parameter int BUF_DEPTH             = `SAP_BUF_DEPTH,
  parameter int SETTLE_CHANGE_FRAMES  = `SAP_SETTLE_CHANGE_FRAMES,
  parameter int SETTLE_POWERUP_FRAMES = `SAP_SETTLE_POWERUP_FRAMES
) (
  input  wire logic                       clk_in,
  input  wire logic                       resetn_in,
  input  wire sap_pkg::sap_port_cfg_type  in_cfg_in,
  input  wire sap_pkg::sap_port_cfg_type  out_cfg_in,
  input  wire logic                       src_from_line_in,
  input  wire sap_pkg::sap_stereo_type    line_sample_in,
  input  wire logic                       line_sample_valid_in,
  input  wire sap_pkg::sap_line_bits_type line_bits_in,
  input  wire logic                       rx_block_start_pin_in,
  input  wire logic                       out_clock_is_recovered_in,
  input  wire logic                       dither_enable_in,
  input  wire logic                       mute_in,
  input  wire logic                       status_clear_in,
  input  wire logic                       in_bit_clock_in,
  input  wire logic                       in_word_clock_in,
  input  wire logic                       in_data_in,
  output logic                            in_bit_clock_out,
  output logic                            in_bit_clock_oe_out,
  output logic                            in_word_clock_out,
  output logic                            in_word_clock_oe_out,
  input  wire logic                       out_bit_clock_in,
  input  wire logic                       out_word_clock_in,
  output logic                            out_bit_clock_out,
  output logic                            out_bit_clock_oe_out,
  output logic                            out_word_clock_out,
  output logic                            out_word_clock_oe_out,
  output logic                            out_data_out,
  output logic [7:0]                      sample_rate_ratio_out,
  output logic                            converter_unlock_flag_out,
  output logic                            converter_overflow_flag_out,
  output logic                            sample_slip_flag_out
);
  import sap_pkg::*;

  localparam int PW = $clog2(BUF_DEPTH);
  localparam int LW = $clog2(BUF_DEPTH + 1);

  function automatic logic [5:0] res_bits(input logic [1:0] code);
    logic [5:0] b;
    case (code)
      `SAP_RES_20: b = `SAP_RES_BITS_20;
      `SAP_RES_16: b = `SAP_RES_BITS_16;
      default:     b = `SAP_RES_BITS_24;
    endcase
    return b;
  endfunction

  // keep the newest n bits, MSB-aligned; fewer bits clocked in simply truncate
  function automatic sap_word_type fit_word(input sap_word_type sh,
                                            input logic [5:0] cnt,
                                            input logic [5:0] lim);
    logic [5:0] n;
    n = (cnt < lim) ? cnt : lim;
    return (n == 6'h00) ? '0 : sh << (`SAP_RES_BITS_24 - n);
  endfunction

  // rectangular dither below the kept bits, saturating at full scale
  function automatic sap_word_type shape(input sap_word_type w,
                                         input logic [7:0] rnd,
                                         input logic [5:0] n,
                                         input logic en);
    sap_word_type keep;
    sap_word_type d;
    logic [24:0]  sum;
    keep = '1;
    keep = keep << (`SAP_RES_BITS_24 - n);
    d    = en ? ({16'h0000, rnd} & ~keep) : '0;
    sum  = {w[23], w} + {1'b0, d};
    if (sum[24] != sum[23]) begin
      sum[23:0] = {1'b0, {23{1'b1}}};
    end
    return sum[23:0] & keep;
  endfunction

  sap_port_ev_type     ev_i, ev_o;

  logic                ds1_r, ds2_r;
  sap_word_type        ish_r, ish_nxt, ileft_r, ileft_nxt, in_word;
  logic [5:0]          icnt_r, icnt_nxt, in_lim;
  logic                push;
  sap_stereo_type      push_word;

  sap_stereo_type      mem [BUF_DEPTH];
  logic [PW-1:0]       wr_r, wr_nxt, rd_r, rd_nxt;
  logic [LW-1:0]       lvl_r, lvl_nxt;
  sap_stereo_type      opair_r, cur_pair;
  logic                pop, pop_ok, push_ok, full;
  logic                ovf_r, ovf_nxt, slip_r, slip_nxt;
  logic [`SAP_RATIO_FRAC-1:0] win_r, win_nxt;
  logic [7:0]          pcnt_r, pcnt_nxt, pinc, ratio_r, ratio_nxt;
  logic [13:0]         settle_r, settle_nxt, limit;
  logic                changed, unlock_r, unlock_nxt;
  sap_lock_state_type  state_r, state_nxt;

  logic [16:0]         lfl_r, lfl_nxt;
  logic [22:0]         lfr_r, lfr_nxt;
  logic [31:0]         osh_r, osh_nxt, frame;
  logic                odata_r, odata_nxt, line_fmt;
  logic [5:0]          o_n, o_bits;
  sap_word_type        o_word;

  // ==========================================================
  // port clocking
  sap_clkgen #(.HALF_DIV(HALF_DIV)) u_in_clk (
    .clk_in            (clk_in),
    .resetn_in         (resetn_in),
    .cfg_in            (in_cfg_in),
    .bit_clock_in      (in_bit_clock_in),
    .word_clock_in     (in_word_clock_in),
    .bit_clock_out     (in_bit_clock_out),
    .bit_clock_oe_out  (in_bit_clock_oe_out),
    .word_clock_out    (in_word_clock_out),
    .word_clock_oe_out (in_word_clock_oe_out),
    .ev_out            (ev_i)
  );

  sap_clkgen #(.HALF_DIV(HALF_DIV)) u_out_clk (
    .clk_in            (clk_in),
    .resetn_in         (resetn_in),
    .cfg_in            (out_cfg_in),
    .bit_clock_in      (out_bit_clock_in),
    .word_clock_in     (out_word_clock_in),
    .bit_clock_out     (out_bit_clock_out),
    .bit_clock_oe_out  (out_bit_clock_oe_out),
    .word_clock_out    (out_word_clock_out),
    .word_clock_oe_out (out_word_clock_oe_out),
    .ev_out            (ev_o)
  );

  // ==========================================================
  // serial input capture
  always_comb begin
    ish_nxt   = ish_r;
    icnt_nxt  = icnt_r;
    ileft_nxt = ileft_r;
    push      = 1'b0;
    push_word = '0;
    in_lim    = in_cfg_in.justify_sel ? res_bits(in_cfg_in.word_resolution)
                                      : `SAP_RES_BITS_24;
    in_word   = fit_word(ish_r, icnt_r, in_lim);
    if (src_from_line_in) begin
      push      = line_sample_valid_in;
      push_word = line_sample_in;
    end else if (ev_i.sample && ev_i.sample_phase) begin
      if (ev_i.left) begin
        push      = 1'b1;
        push_word = {ileft_r, in_word};
      end else begin
        ileft_nxt = in_word;
      end
      // with the delay set, the first bit slot of the phase carries no data
      ish_nxt  = in_cfg_in.first_bit_delay ? '0 : {23'h000000, ds2_r};
      icnt_nxt = in_cfg_in.first_bit_delay ? 6'h00 : 6'h01;
    end else if (ev_i.sample &&
                 (in_cfg_in.justify_sel || icnt_r < `SAP_RES_BITS_24)) begin
      ish_nxt = {ish_r[22:0], ds2_r};
      if (icnt_r != 6'h3F) begin
        icnt_nxt = icnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ds1_r   <= 1'b0;
      ds2_r   <= 1'b0;
      ish_r   <= '0;
      icnt_r  <= 6'h00;
      ileft_r <= '0;
    end else begin
      ds1_r   <= in_data_in;
      ds2_r   <= ds1_r;
      ish_r   <= ish_nxt;
      icnt_r  <= icnt_nxt;
      ileft_r <= ileft_nxt;
    end
  end

  // ==========================================================
  // converter buffer, ratio and lock tracking
  always_comb begin
    pop      = ev_o.launch && ev_o.launch_phase && ev_o.left;
    full     = lvl_r == LW'(BUF_DEPTH);
    pop_ok   = pop && (lvl_r != '0);
    push_ok  = push && (!full || pop_ok);
    cur_pair = pop_ok ? mem[rd_r] : opair_r; // empty buffer repeats the last pair
    wr_nxt   = push_ok ? wr_r + PW'(1) : wr_r;
    rd_nxt   = pop_ok ? rd_r + PW'(1) : rd_r;
    lvl_nxt  = lvl_r + LW'(push_ok) - LW'(pop_ok);
    ovf_nxt  = (push && !push_ok) | (ovf_r & ~status_clear_in);
    slip_nxt = (!out_cfg_in.master_select &&
                ((pop && !pop_ok) || (push && !push_ok))) |
               (slip_r & ~status_clear_in);
    pinc       = (push && pcnt_r != 8'hFF) ? pcnt_r + 8'h01 : pcnt_r;
    pcnt_nxt   = pinc;
    win_nxt    = win_r;
    ratio_nxt  = ratio_r;
    state_nxt  = state_r;
    settle_nxt = settle_r;
    changed    = ({1'b0, pinc} > {1'b0, ratio_r} + `SAP_RATIO_TOL) ||
                 ({1'b0, ratio_r} > {1'b0, pinc} + `SAP_RATIO_TOL);
    limit      = (state_r == SAP_ST_POWERUP) ? 14'(SETTLE_POWERUP_FRAMES)
                                             : 14'(SETTLE_CHANGE_FRAMES);
    if (pop) begin
      // input samples per 64 output frames is the ratio in 2.6 form
      win_nxt = win_r + `SAP_RATIO_FRAC'(1);
      if (&win_r) begin
        ratio_nxt = pinc;
        pcnt_nxt  = 8'h00;
      end
      if (&win_r && changed) begin
        state_nxt  = SAP_ST_TRACK;
        settle_nxt = 14'h0000;
      end else begin
        case (state_r)
          SAP_ST_POWERUP, SAP_ST_TRACK: begin
            if (settle_r + 14'h0001 >= limit) begin
              state_nxt = SAP_ST_LOCKED;
            end else begin
              settle_nxt = settle_r + 14'h0001;
            end
          end
          default: begin
            state_nxt = state_r;
          end
        endcase
      end
    end
    // conversion never stops while unlocked; only quality suffers
    unlock_nxt = state_nxt != SAP_ST_LOCKED;
  end

  always_ff @(posedge clk_in) begin
    if (push_ok) begin
      mem[wr_r] <= push_word;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_r     <= '0;
      rd_r     <= '0;
      lvl_r    <= '0;
      opair_r  <= '0;
      ovf_r    <= 1'b0;
      slip_r   <= 1'b0;
      win_r    <= '0;
      pcnt_r   <= 8'h00;
      ratio_r  <= `SAP_RATIO_RESET;
      settle_r <= 14'h0000;
      state_r  <= SAP_ST_POWERUP;
      unlock_r <= 1'b1;
    end else begin
      wr_r     <= wr_nxt;
      rd_r     <= rd_nxt;
      lvl_r    <= lvl_nxt;
      opair_r  <= cur_pair;
      ovf_r    <= ovf_nxt;
      slip_r   <= slip_nxt;
      win_r    <= win_nxt;
      pcnt_r   <= pcnt_nxt;
      ratio_r  <= ratio_nxt;
      settle_r <= settle_nxt;
      state_r  <= state_nxt;
      unlock_r <= unlock_nxt;
    end
  end

  // ==========================================================
  // serial output formatting
  always_comb begin
    lfl_nxt  = pop ? {lfl_r[15:0], ^(lfl_r & `SAP_LFSR_L_TAPS)} : lfl_r;
    lfr_nxt  = pop ? {lfr_r[21:0], ^(lfr_r & `SAP_LFSR_R_TAPS)} : lfr_r;
    line_fmt = out_cfg_in.word_resolution == `SAP_RES_LINE;
    o_n      = line_fmt ? `SAP_RES_BITS_24 : res_bits(out_cfg_in.word_resolution);
    o_bits   = out_cfg_in.bitclk_rate ? `SAP_PHASE_BITS_R1 : `SAP_PHASE_BITS_R0;
    // two generators of different length keep the channels uncorrelated
    o_word   = shape(ev_o.left ? cur_pair.left : cur_pair.right,
                     ev_o.left ? lfl_r[7:0] : lfr_r[7:0],
                     o_n, dither_enable_in && !line_fmt);
    if (line_fmt) begin
      frame = out_clock_is_recovered_in ?
              {o_word, line_bits_in.validity, line_bits_in.user,
               line_bits_in.status, rx_block_start_pin_in, 4'h0} : '0;
    end else if (out_cfg_in.justify_sel) begin
      // phase length taken from bitclk_rate, so as slave right-justify only fits word clocks whose phase has that many bits
      frame = ({8'h00, o_word} >> (`SAP_RES_BITS_24 - o_n))
              << (`SAP_FRAME_BITS - o_bits);
    end else begin
      frame = {o_word, 8'h00};
    end
    if (out_cfg_in.first_bit_delay) begin
      frame = {1'b0, frame[31:1]};
    end
    if (mute_in) begin
      frame = '0;
    end
    osh_nxt   = osh_r;
    odata_nxt = odata_r;
    if (ev_o.launch) begin
      if (ev_o.launch_phase) begin
        odata_nxt = frame[31];
        osh_nxt   = frame << 1;
      end else begin
        odata_nxt = osh_r[31];
        osh_nxt   = osh_r << 1;
      end
    end
    if (mute_in) begin
      odata_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lfl_r   <= `SAP_LFSR_L_SEED;
      lfr_r   <= `SAP_LFSR_R_SEED;
      osh_r   <= 32'h00000000;
      odata_r <= 1'b0;
    end else begin
      lfl_r   <= lfl_nxt;
      lfr_r   <= lfr_nxt;
      osh_r   <= osh_nxt;
      odata_r <= odata_nxt;
    end
  end

  assign out_data_out                = odata_r;
  assign sample_rate_ratio_out       = ratio_r;
  assign converter_unlock_flag_out   = unlock_r;
  assign converter_overflow_flag_out = ovf_r;
  assign sample_slip_flag_out        = slip_r;

endmodule

// [sap_serial_src_bench.sv]
`timescale 1ns/1ps
module sap_serial_src_bench;
  import sap_pkg::*;
  localparam sap_word_type LW = 24'hA5C3F1;
  localparam sap_word_type RW = 24'h3C0F96;
  logic             clk_in = 1'b0;
  logic             resetn_in;
  sap_port_cfg_type out_cfg = 8'h80;
  sap_port_cfg_type in_cfg  = 8'h00;
  logic             dither  = 1'b0;
  logic             slip, ioe;
  sap_stereo_type   lsample = 48'h123456654321;
  logic             src_line = 1'b0, lvalid = 1'b0, mute = 1'b0, sclr = 1'b0;
  logic             ibc, iwc, idat, obc, owc, odat, pbc, pwc, ooe, unl, ovf;
  logic [7:0]       ratio;
  int               feed = 0, fcnt = 0, bad_count = 0, num_checks = 0;

  sap_serial_src #(.SETTLE_CHANGE_FRAMES(20), .SETTLE_POWERUP_FRAMES(16)) DUT (
    .clk_in(clk_in), .resetn_in(resetn_in), .in_cfg_in(in_cfg), .out_cfg_in(out_cfg),
    .src_from_line_in(src_line), .line_sample_in(lsample), .line_sample_valid_in(lvalid),
    .line_bits_in(3'h5), .rx_block_start_pin_in(1'b0), .out_clock_is_recovered_in(1'b0),
    .dither_enable_in(dither), .mute_in(mute), .status_clear_in(sclr),
    .in_bit_clock_in(ibc), .in_word_clock_in(iwc), .in_data_in(idat),
    .in_bit_clock_out(), .in_bit_clock_oe_out(ioe),
    .in_word_clock_out(), .in_word_clock_oe_out(),
    .out_bit_clock_in(ibc), .out_word_clock_in(iwc), .out_bit_clock_out(obc),
    .out_bit_clock_oe_out(ooe), .out_word_clock_out(owc), .out_word_clock_oe_out(),
    .out_data_out(odat), .sample_rate_ratio_out(ratio), .converter_unlock_flag_out(unl),
    .converter_overflow_flag_out(ovf), .sample_slip_flag_out(slip));
  sap_audio_source #(.LEFT_WORD(LW), .RIGHT_WORD(RW)) src (.clk_in(clk_in),
    .bit_clock_out(ibc), .word_clock_out(iwc), .data_out(idat));

  initial forever #10 clk_in = ~clk_in;
  // line pairs every feed+1 clocks set the input rate
  always @(posedge clk_in) begin
    fcnt   <= (fcnt >= feed) ? 0 : fcnt + 1;
    lvalid <= (feed != 0) && (fcnt == 0);
  end

  task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick();
    pbc = obc;
    pwc = owc;
    @(posedge clk_in);
    #1;
  endtask
  // one word, from the word clock edge into level lvl
  task automatic grab(input logic lvl, output sap_word_type w);
    int t;
    t = 0;
    while (!(pwc === ~lvl && owc === lvl) && t < 2000) begin
      tick();
      t++;
    end
    for (int i = 23; i >= 0; i--) begin
      t = 0;
      while (i != 23 && !(pbc === 1'b1 && obc === 1'b0) && t < 64) begin
        tick();
        t++;
      end
      tick();
      w[i] = odat;
    end
  endtask

  task automatic t_format();
    sap_word_type w;
    for (int r = 0; r < 3; r++) begin
      @(posedge clk_in);
      out_cfg.word_resolution <= 2'(r);
      // at 24 bits the scaled dither must vanish entirely
      dither <= (r == 0);
      repeat (1200) tick();
      grab(1'b1, w);
      chk("left word", LW & (24'hFFFFFF << (4 * r)), w);
      grab(1'b0, w);
      chk("right word", RW & (24'hFFFFFF << (4 * r)), w);
    end
    chk("bclk drive", 24'h1, {23'h0, ooe});
    chk("in clock drive", 24'h0, {23'h0, ioe});
  endtask
  // source sends 24 data bits then 8 toggling slots; RJ 20 keeps the newest 20
  task automatic t_rjust();
    sap_word_type w;
    @(posedge clk_in);
    in_cfg.justify_sel      <= 1'b1;
    in_cfg.word_resolution  <= 2'h1;
    out_cfg.word_resolution <= 2'h0;
    repeat (1800) tick();
    grab(1'b1, w);
    chk("rj left word", {LW[11:0], 8'h55, 4'h0}, w);
    grab(1'b0, w);
    chk("rj right word", {RW[11:0], 8'h55, 4'h0}, w);
    @(posedge clk_in);
    in_cfg <= 8'h00;
  endtask
  task automatic t_mute();
    sap_word_type w;
    @(posedge clk_in);
    mute <= 1'b1;
    repeat (600) tick();
    grab(1'b1, w);
    chk("muted word", 24'h0, w);
    @(posedge clk_in);
    mute <= 1'b0;
  endtask
  task automatic t_rate();
    int t;
    @(posedge clk_in);
    out_cfg  <= 8'hC0;
    src_line <= 1'b1;
    feed     <= 255;
    repeat (39000) tick();
    chk("ratio 1:1", 24'h40, {16'h0, ratio});
    chk("unlock steady", 24'h0, {23'h0, unl});
    @(posedge clk_in);
    feed <= 127;
    t = 0;
    while (ratio !== 8'h80 && t < 40000) begin
      tick();
      t++;
    end
    repeat (4) tick();
    chk("ratio 2:1", 24'h80, {16'h0, ratio});
    chk("unlock moving", 24'h1, {23'h0, unl});
    chk("overflow", 24'h1, {23'h0, ovf});
    chk("slip as master", 24'h0, {23'h0, slip});
    @(posedge clk_in);
    feed <= 0;
    // a last pulse from the old feed must not meet the clear
    @(posedge clk_in);
    sclr <= 1'b1;
    @(posedge clk_in);
    sclr <= 1'b0;
    repeat (4) tick();
    chk("overflow clear", 24'h0, {23'h0, ovf});
    // slave output on the source clocks drains the unfed buffer
    @(posedge clk_in);
    out_cfg <= 8'h00;
    repeat (3500) tick();
    chk("slip as slave", 24'h1, {23'h0, slip});
  endtask

  task automatic close_out();
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_in);
    bad_count++;
    close_out();
  end
  initial begin
    resetn_in = 1'b0;
    repeat (12) @(posedge clk_in);
    chk("ratio reset", 24'h40, {16'h0, ratio});
    chk("unlock reset", 24'h1, {23'h0, unl});
    resetn_in <= 1'b1;
    t_format();
    t_rjust();
    t_mute();
    t_rate();
    close_out();
  end
endmodule

// [sap_serial_src_sva.sv]
`timescale 1ns/1ps
module sap_serial_src_sva (
  input wire logic                      clk_in,
  input wire logic                      resetn_in,
  input wire sap_pkg::sap_port_cfg_type out_cfg_in,
  input wire logic                      mute_in,
  input wire logic                      status_clear_in,
  input wire logic                      out_bit_clock_out,
  input wire logic                      out_bit_clock_oe_out,
  input wire logic                      out_word_clock_out,
  input wire logic                      out_data_out,
  input wire logic [7:0]                sample_rate_ratio_out,
  input wire logic                      converter_unlock_flag_out,
  input wire logic                      converter_overflow_flag_out
);
  import sap_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ==========================================================
  // output port: master drive and timing (edge checks at bit clock polarity 0), mute in any mode
  chk_oe_master: assert property (out_cfg_in.master_select |=> out_bit_clock_oe_out)
    else $error("bit clock not driven as master");
  chk_bclk_rate: assert property (out_cfg_in.master_select && $changed(out_bit_clock_out)
    |=> $stable(out_bit_clock_out) [*3] ##1 $changed(out_bit_clock_out))
    else $error("master bit clock half period wrong");
  chk_wclk_edge: assert property (out_cfg_in.master_select && !out_cfg_in.bitclk_polarity
    && $changed(out_word_clock_out) |-> $fell(out_bit_clock_out))
    else $error("word clock moved off a falling bit clock");
  chk_data_launch: assert property (out_cfg_in.master_select && !mute_in && !$past(mute_in)
    && !out_cfg_in.bitclk_polarity && $changed(out_data_out)
    |-> $past(out_bit_clock_out, 2) && !$past(out_bit_clock_out))
    else $error("data changed off the launch edge");
  chk_mute_silent: assert property (mute_in |=> !out_data_out)
    else $error("serial output not silent under mute");
  // ==========================================================
  // converter status
  chk_ratio_start: assert property ($rose(resetn_in) |-> sample_rate_ratio_out == 8'h40)
    else $error("ratio does not start at one");
  chk_unlock_start: assert property ($rose(resetn_in) |-> converter_unlock_flag_out)
    else $error("converter not unlocked after reset");
  chk_ovf_sticky: assert property (converter_overflow_flag_out && !status_clear_in
    |=> converter_overflow_flag_out)
    else $error("overflow flag dropped without clear");
endmodule

bind sap_serial_src sap_serial_src_sva u_sva (.clk_in(clk_in), .resetn_in(resetn_in),
  .out_cfg_in(out_cfg_in), .mute_in(mute_in), .status_clear_in(status_clear_in),
  .out_bit_clock_out(out_bit_clock_out), .out_bit_clock_oe_out(out_bit_clock_oe_out),
  .out_word_clock_out(out_word_clock_out), .out_data_out(out_data_out),
  .sample_rate_ratio_out(sample_rate_ratio_out),
  .converter_unlock_flag_out(converter_unlock_flag_out),
  .converter_overflow_flag_out(converter_overflow_flag_out));
